// File: src/dsc_pkg.sv
// Purpose: shared constants for the deep-sleep power and clock controller
// Assumes: APB slave, 32-bit data, word-aligned registers
// Notes:   offsets are byte addresses
package dsc_pkg;
  // register byte offsets
  localparam logic [11:0] DSC_OFF_CTRL     = 12'h000;
  localparam logic [11:0] DSC_OFF_CLKCFG   = 12'h004;
  localparam logic [11:0] DSC_OFF_LEGACY   = 12'h008;
  localparam logic [11:0] DSC_OFF_POWER    = 12'h00C;
  localparam logic [11:0] DSC_OFF_PERIPH   = 12'h010;
  localparam logic [11:0] DSC_OFF_APERTURE = 12'h014;
  localparam logic [11:0] DSC_OFF_SECTOR   = 12'h018;
  localparam logic [11:0] DSC_OFF_FLSIZE   = 12'h01C;
  localparam logic [11:0] DSC_OFF_STATUS   = 12'h020;
  localparam logic [11:0] DSC_OFF_RUNCFG   = 12'h024;
  // control bits
  localparam int DSC_CTRL_SLEEP_BIT   = 0;
  localparam int DSC_CTRL_GATING_BIT  = 1;
  localparam int DSC_CTRL_LEGACY_BIT  = 2;
  // clock configuration fields
  localparam int DSC_DIV_LSB          = 0;
  localparam int DSC_DIV_W            = 10;
  localparam int DSC_SRC_LSB          = 16;
  localparam int DSC_PREC_PD_BIT      = 20;
  localparam int DSC_MAIN_PD_BIT      = 21;
  localparam int DSC_LEGDIV_W         = 6;
  // power fields
  localparam int DSC_FLASH_BIT        = 0;
  localparam int DSC_SRAM_LSB         = 4;
  localparam int DSC_REG_SLEEP_BIT    = 8;
  localparam int DSC_TEMP_LP_BIT      = 9;
  // aperture command fields
  localparam int DSC_AP_PORT_LSB      = 0;
  localparam int DSC_AP_SET_BIT       = 8;
  localparam int DSC_NUM_PORTS        = 10;
  // ports with a select: A B C E F H J
  localparam logic [9:0] DSC_AP_ELIGIBLE = 10'h2B7;
  // reset values
  localparam logic [9:0] DSC_DIV_RST    = 10'h000;
  localparam logic [5:0] DSC_LEGDIV_RST = 6'h00;
  localparam logic [31:0] DSC_RUNCFG_RST = 32'h0000_0000;

  typedef enum logic [1:0] {
    DSC_SRC_MAIN  = 2'h0,  // dsleep_src_main_osc
    DSC_SRC_PREC  = 2'h1,  // dsleep_src_precision_internal
    DSC_SRC_LOWF  = 2'h2,  // dsleep_src_low_freq_internal
    DSC_SRC_HIB   = 2'h3   // dsleep_src_hib_32k
  } dsc_src_t;

  typedef enum logic [1:0] {
    DSC_SRAM_FULL    = 2'h0,
    DSC_SRAM_STANDBY = 2'h1,
    DSC_SRAM_LOWEST  = 2'h3
  } dsc_sram_t;

  typedef enum logic [3:0] {
    DSC_ST_RUN     = 4'b0001,
    DSC_ST_SLEEP   = 4'b0010,
    DSC_ST_RESTORE = 4'b0100,
    DSC_ST_ENTER   = 4'b1000
  } dsc_state_t;
endpackage

// File: src/dsc_ctrl.sv
// Purpose: deep-sleep clock, oscillator, memory power and aperture control
// Assumes: single clock, APB slave, zero-wait answers
// Notes:   analog parts are steered by the registered outputs below
//
// Design decisions made here: the APB slave port and the address map.
`timescale 1ns/1ps
module dsc_ctrl
  import dsc_pkg::*;
#(
  parameter int          NUM_PERIPH   = 16,
  parameter logic [31:0] SECTOR_BYTES = 32'h0000_4000,
  parameter logic [31:0] FLASH_BYTES  = 32'h0010_0000,
  parameter logic [9:0]  AHB_ONLY     = 10'h000,
  parameter int          DIV_MAX      = 1024
) (
  // clock and reset
  input  wire logic                  ref_clk,
  input  wire logic                  rst_n,
  // apb slave
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [11:0]           paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  // system side
  input  wire logic [NUM_PERIPH-1:0] periphWake,
  input  wire logic                  hibPresent,
  output logic                       cpuHalt,
  output logic                       deepSleepActive,
  output logic      [NUM_PERIPH-1:0] periphClkEn,
  output logic      [1:0]            clkSrcSel,
  output logic      [9:0]            clkDivide,
  output logic                       mainOscOn,
  output logic                       precOscOn,
  output logic                       flashLowPower,
  output logic      [1:0]            sramPower,
  output logic                       regulatorSleep,
  output logic                       tempLowPower,
  output logic      [9:0]            gpioAhbSel,
  output logic      [9:0]            gpioApbSel
);

  // elaboration checks; readback and divider fields have no room beyond
  if (NUM_PERIPH < 1 || NUM_PERIPH > 32) begin : g_chk_periph
    $error("NUM_PERIPH out of range");
  end
  if (DIV_MAX < 1 || DIV_MAX > 1024) begin : g_chk_div
    $error("DIV_MAX out of range");
  end
  if (SECTOR_BYTES == 32'h0000_0000) begin : g_chk_sector
    $error("SECTOR_BYTES must not be zero");
  end
  if (SECTOR_BYTES > FLASH_BYTES) begin : g_chk_flash
    $error("FLASH_BYTES below one sector");
  end

  // registers
  logic [2:1]            ctrl_ff;
  logic                  sleepReq_ff;
  logic [31:0]           clkCfg_ff;
  logic [31:0]           legacy_ff;
  logic [31:0]           power_ff;
  logic [NUM_PERIPH-1:0] periph_ff;
  logic [9:0]            aperture_ff;
  logic [31:0]           runCfg_ff;
  dsc_state_t            state_ff;
  dsc_state_t            nxt_state;
  logic [31:0]           nxt_rdata;
  logic                  addrOk;
  logic                  wrEn;
  logic                  wake;
  logic [1:0]            src;
  logic [9:0]            div;
  logic                  sleeping;

  assign wrEn = psel & penable & pwrite & ~pslverr;

  // zero-wait slave: ready rises in the access phase only
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~addrOk;
      prdata  <= (psel & ~penable & ~pwrite) ? nxt_rdata : 32'h0000_0000;
    end
  end

  always_comb begin
    addrOk    = 1'b1;
    nxt_rdata = 32'h0000_0000;
    case (paddr)
      DSC_OFF_CTRL:     nxt_rdata = {29'h0, ctrl_ff, sleepReq_ff};
      DSC_OFF_CLKCFG:   nxt_rdata = clkCfg_ff;
      DSC_OFF_LEGACY:   nxt_rdata = legacy_ff;
      DSC_OFF_POWER:    nxt_rdata = power_ff;
      DSC_OFF_PERIPH:   nxt_rdata = 32'(periph_ff);
      DSC_OFF_APERTURE: nxt_rdata = {22'h0, aperture_ff};
      DSC_OFF_SECTOR:   nxt_rdata = SECTOR_BYTES;
      DSC_OFF_FLSIZE:   nxt_rdata = FLASH_BYTES;
      DSC_OFF_STATUS:   nxt_rdata = {28'h0, state_ff};
      DSC_OFF_RUNCFG:   nxt_rdata = runCfg_ff;
      default:          addrOk = 1'b0;
    endcase
  end

  // configuration registers; sleep request bit handled with the fsm
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_ff      <= 2'b00;
      clkCfg_ff    <= {22'h0, DSC_DIV_RST};
      legacy_ff    <= {26'h0, DSC_LEGDIV_RST};
      power_ff     <= 32'h0000_0000;
      periph_ff    <= '0;
      runCfg_ff    <= DSC_RUNCFG_RST;
    end else if (wrEn) begin
      case (paddr)
        DSC_OFF_CTRL:   ctrl_ff <= pwdata[2:1];
        DSC_OFF_CLKCFG: clkCfg_ff <= pwdata & 32'h0033_03FF;
        DSC_OFF_LEGACY: legacy_ff <= pwdata & 32'h0033_003F;
        // sram code 2 is unused; not folded, the or puts bit 5 back on bit 5, so code 2 is stored as 2
        DSC_OFF_POWER:  power_ff <= (pwdata & 32'h0000_0331)
                                    | {26'h0, pwdata[5], 5'h0};
        DSC_OFF_PERIPH: periph_ff <= pwdata[NUM_PERIPH-1:0];
        DSC_OFF_RUNCFG: runCfg_ff <= pwdata;
        default:        ;
      endcase
    end
  end

  // one eligible port per write, others ignored
  logic           apWrite;
  wire logic [9:0] nxt_aperture;

  assign apWrite = wrEn && paddr == DSC_OFF_APERTURE;

  // per port: only an eligible port named by the write moves
  for (genvar p = 0; p < DSC_NUM_PORTS; p++) begin : g_port
    assign nxt_aperture[p] =
      (apWrite && DSC_AP_ELIGIBLE[p]
       && pwdata[DSC_AP_PORT_LSB +: 4] == 4'(p))
      ? pwdata[DSC_AP_SET_BIT] : aperture_ff[p];
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      aperture_ff <= 10'h000;
    end else begin
      aperture_ff <= nxt_aperture;
    end
  end

  // wake levels come from peripherals on other clocks in deep sleep:
  // three flops, a bit moves only when stages two and three agree
  logic [NUM_PERIPH-1:0] wakeMeta_ff;
  logic [NUM_PERIPH-1:0] wakeSync_ff;
  logic [NUM_PERIPH-1:0] wakeLate_ff;
  logic [NUM_PERIPH-1:0] wakeLvl_ff;
  logic [NUM_PERIPH-1:0] wakeAgree;

  assign wakeAgree = ~(wakeSync_ff ^ wakeLate_ff);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wakeMeta_ff <= '0;
      wakeSync_ff <= '0;
      wakeLate_ff <= '0;
      wakeLvl_ff  <= '0;
    end else begin
      wakeMeta_ff <= periphWake;
      wakeSync_ff <= wakeMeta_ff;
      wakeLate_ff <= wakeSync_ff;
      // costs a few cycles of wake latency, buys glitch immunity
      wakeLvl_ff  <= (wakeAgree & wakeSync_ff) | (~wakeAgree & wakeLvl_ff);
    end
  end

  // wake only from flagged peripherals when gating
  assign wake = ctrl_ff[DSC_CTRL_GATING_BIT]
                ? |(wakeLvl_ff & periph_ff) : |wakeLvl_ff;
  assign sleeping = (state_ff == DSC_ST_SLEEP);

  // halt until wake, then restore and resume
  always_comb begin
    case (state_ff)
      DSC_ST_RUN:     nxt_state = sleepReq_ff
                                  ? DSC_ST_ENTER : DSC_ST_RUN;
      DSC_ST_ENTER:   nxt_state = DSC_ST_SLEEP;
      DSC_ST_SLEEP:   nxt_state = wake ? DSC_ST_RESTORE : DSC_ST_SLEEP;
      DSC_ST_RESTORE: nxt_state = DSC_ST_RUN;
      default:        nxt_state = DSC_ST_RUN;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff    <= DSC_ST_RUN;
      sleepReq_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      // request self-clears once sleep is entered
      if (state_ff == DSC_ST_ENTER)
        sleepReq_ff <= 1'b0;
      else if (wrEn && paddr == DSC_OFF_CTRL && state_ff == DSC_ST_RUN)
        sleepReq_ff <= pwdata[DSC_CTRL_SLEEP_BIT];
    end
  end

  // legacy mode takes source and 1..64 divider
  assign src = ctrl_ff[DSC_CTRL_LEGACY_BIT] ? legacy_ff[17:16]
                                            : clkCfg_ff[17:16];
  // stored value n-1 divides by n, clipped to DIV_MAX
  assign div = ctrl_ff[DSC_CTRL_LEGACY_BIT] ? {4'h0, legacy_ff[5:0]}
             : (clkCfg_ff[9:0] > 10'(DIV_MAX - 1)) ? 10'(DIV_MAX - 1)
             : clkCfg_ff[9:0];
  // run divider clipped the same way; the legacy divider is not clipped to DIV_MAX
  logic [9:0] runDiv;
  assign runDiv = (runCfg_ff[9:0] > 10'(DIV_MAX - 1)) ? 10'(DIV_MAX - 1)
                : runCfg_ff[9:0];

  // outputs switch back to run config on restore
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cpuHalt         <= 1'b0;
      deepSleepActive <= 1'b0;
      periphClkEn     <= '1;
      clkSrcSel       <= 2'h0;
      clkDivide       <= 10'h000;
      mainOscOn       <= 1'b1;
      precOscOn       <= 1'b1;
      flashLowPower   <= 1'b0;
      sramPower       <= 2'h0;
      regulatorSleep  <= 1'b0;
      tempLowPower    <= 1'b0;
    end else if (nxt_state == DSC_ST_SLEEP) begin
      cpuHalt         <= 1'b1;
      deepSleepActive <= 1'b1;
      periphClkEn     <= ctrl_ff[DSC_CTRL_GATING_BIT] ? periph_ff : '1;
      clkSrcSel       <= src;
      clkDivide       <= div;
      // no powerdown of the oscillator in use
      mainOscOn       <= ~clkCfg_ff[DSC_MAIN_PD_BIT] | (src == DSC_SRC_MAIN);
      precOscOn       <= ~clkCfg_ff[DSC_PREC_PD_BIT] | (src == DSC_SRC_PREC);
      flashLowPower   <= power_ff[DSC_FLASH_BIT];
      sramPower       <= power_ff[5:4];
      regulatorSleep  <= power_ff[DSC_REG_SLEEP_BIT];
      tempLowPower    <= power_ff[DSC_TEMP_LP_BIT];
    end else begin
      cpuHalt         <= (nxt_state == DSC_ST_ENTER) | sleeping;
      deepSleepActive <= 1'b0;
      periphClkEn     <= '1;
      clkSrcSel       <= runCfg_ff[17:16];
      clkDivide       <= runDiv;
      mainOscOn       <= 1'b1;
      precOscOn       <= 1'b1;
      flashLowPower   <= 1'b0;
      sramPower       <= 2'h0;
      regulatorSleep  <= 1'b0;
      tempLowPower    <= 1'b0;
    end
  end

  // route per port; ahb-only ports lose apb
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      gpioAhbSel <= 10'h000;
      gpioApbSel <= 10'h000;
    end else begin
      gpioAhbSel <= aperture_ff | (AHB_ONLY & ~DSC_AP_ELIGIBLE);
      gpioApbSel <= ~aperture_ff & ~AHB_ONLY;
    end
  end

endmodule

// File: test/dsc_ctrl_properties.sv
// Purpose: port checker for dsc_ctrl
// Assumes: single clock, async active-low reset
// Notes:   attached by the bind below the module
`timescale 1ns/1ps
module dsc_ctrl_properties
  import dsc_pkg::*;
#(
  parameter int NUM_PERIPH = 16,
  parameter int DIV_MAX    = 1024,
  parameter logic [9:0] AHB_ONLY = 10'h000
) (
  // clock and reset
  input wire logic                  ref_clk,
  input wire logic                  rst_n,
  // apb
  input wire logic                  psel,
  input wire logic                  penable,
  input wire logic                  pready,
  input wire logic                  pslverr,
  // sleep and clocks
  input wire logic [NUM_PERIPH-1:0] periphWake,
  input wire logic                  cpuHalt,
  input wire logic                  deepSleepActive,
  input wire logic [NUM_PERIPH-1:0] periphClkEn,
  input wire logic [1:0]            clkSrcSel,
  input wire logic [9:0]            clkDivide,
  input wire logic                  mainOscOn,
  input wire logic                  precOscOn,
  // apertures
  input wire logic [9:0]            gpioAhbSel,
  input wire logic [9:0]            gpioApbSel
);
  default clocking dcb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  AST_APB_ANSWER: assert property (
    psel && !penable |=> pready) else $error("apb answer missing");
  AST_SLEEP_HALTS: assert property (
    deepSleepActive |-> cpuHalt) else $error("cpu runs in sleep");
  AST_HALT_FIRST: assert property (
    $rose(deepSleepActive) |-> $past(cpuHalt)) else $error("halt late");
  AST_RESTORE_HALTED: assert property (
    $fell(deepSleepActive) |-> cpuHalt) else $error("resumed too early");
  AST_RUN_CLOCKED: assert property (
    !cpuHalt |-> &periphClkEn) else $error("clock gated in run");
  AST_WAKE_BOUND: assert property (
    deepSleepActive && |(periphWake & periphClkEn) |-> ##[1:6]
    !deepSleepActive) else $error("flagged wake ignored");
  AST_OSC_KEPT: assert property (
    deepSleepActive |-> (clkSrcSel != DSC_SRC_MAIN || mainOscOn) &&
    (clkSrcSel != DSC_SRC_PREC || precOscOn)) else $error("source osc off");
  AST_DIV_LIMIT: assert property (
    clkDivide <= DIV_MAX - 1) else $error("divider out of range");
  AST_APER_EXCL: assert property (
    !(|(gpioAhbSel & gpioApbSel))) else $error("port on both buses");
  AST_APER_ELIG: assert property (
    (gpioAhbSel & ~DSC_AP_ELIGIBLE & ~AHB_ONLY) == 10'h000)
    else $error("bad port");
  AST_ONE_PORT: assert property (
    $countones(gpioAhbSel ^ $past(gpioAhbSel)) <= 1) else $error("2 ports");

  CV_SLEEP: cover property ($rose(deepSleepActive));
  CV_WAKE: cover property ($fell(cpuHalt));
  CV_ERR: cover property (pslverr);
endmodule

bind dsc_ctrl dsc_ctrl_properties #(
  .NUM_PERIPH(NUM_PERIPH),
  .DIV_MAX(DIV_MAX),
  .AHB_ONLY(AHB_ONLY)
) i_props (
  .ref_clk, .rst_n, .psel, .penable, .pready, .pslverr, .periphWake,
  .cpuHalt, .deepSleepActive, .periphClkEn, .clkSrcSel, .clkDivide,
  .mainOscOn, .precOscOn, .gpioAhbSel, .gpioApbSel
);

// File: test/dsc_ctrl_bench.sv
// Purpose: self-checking bench for dsc_ctrl
// Assumes: run config left at reset, so wake restores zeros
// Notes:   port C made ahb-only; it has a select, so only its apb side is forced off
`timescale 1ns/1ps
module dsc_ctrl_bench import dsc_pkg::*;;
  localparam logic [9:0]  AHB_ONLY = 10'h004;
  localparam logic [31:0] SEC_B    = 32'h0000_0400;
  localparam logic [31:0] FLS_B    = 32'h0004_0000;
  logic        ref_clk, pready, pslverr, cpuHalt, deepSleepActive, err;
  logic        rst_n = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic        mainOscOn, precOscOn, flashLowPower, regulatorSleep;
  logic        tempLowPower, gate, leg, hibPresent = 1'h1;
  logic [1:0]  clkSrcSel, sramPower, src;
  logic [9:0]  clkDivide, gpioAhbSel, gpioApbSel, expAhb, div;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd, pd, pw, seed = 32'h63;
  logic [15:0] periphWake = 16'h0, periphClkEn, mask;
  int          n_errors = 0, n_compared = 0, cycles = 0, i;

  dsc_ctrl #(.SECTOR_BYTES(SEC_B), .FLASH_BYTES(FLS_B), .AHB_ONLY(AHB_ONLY))
    i_dsc_ctrl (.ref_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .periphWake, .hibPresent, .cpuHalt,
    .deepSleepActive, .periphClkEn, .clkSrcSel, .clkDivide, .mainOscOn,
    .precOscOn, .flashLowPower, .sramPower, .regulatorSleep, .tempLowPower,
    .gpioAhbSel, .gpioApbSel);

  initial begin
    ref_clk = 1'h0;
    forever #4 ref_clk = ~ref_clk;
  end
  // run needs under 3000 cycles
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_errors++;
      end_of_test();
    end
  end

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic check(input logic [31:0] got, input logic [31:0] want);
    n_compared++;
    if (got !== want) begin
      n_errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, want);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    int k;
    k = 0;
    psel    <= 1'h1;
    penable <= 1'h0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge ref_clk);
    penable <= 1'h1;
    do begin
      @(posedge ref_clk);
      k++;
    end while (pready !== 1'h1 && k < 20);
    rd  = prdata;
    err = pslverr;
    if (k == 20) check(32'h0, 32'h1);
    psel    <= 1'h0;
    penable <= 1'h0;
    @(posedge ref_clk);
  endtask
  task automatic waitFor(input logic onSleep, input logic v);
    int k;
    for (k = 0; k < 50 && (onSleep ? deepSleepActive : cpuHalt) !== v; k++)
      @(posedge ref_clk);
    check(onSleep ? deepSleepActive : cpuHalt, v);
  endtask
  task automatic end_of_test();
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'h1;
    apb(1'h0, DSC_OFF_SECTOR, 32'h0);
    check(rd, SEC_B);
    apb(1'h0, DSC_OFF_FLSIZE, 32'h0);
    check(rd, FLS_B);
    apb(1'h0, DSC_OFF_STATUS, 32'h0);
    check(rd, 32'h1);
    apb(1'h1, 12'h0FC, 32'hFFFF_FFFF);
    check(err, 1'h1);
    // set then clear every port select, eligible or not
    expAhb = 10'h000;
    for (i = 0; i < 20; i++) begin
      apb(1'h1, DSC_OFF_APERTURE, (i < 10 ? 32'h100 : 32'h0) | (i % 10));
      if (DSC_AP_ELIGIBLE[i % 10]) expAhb[i % 10] = (i < 10);
      // routing flops update one edge after the select lands
      @(posedge ref_clk);
      check(gpioAhbSel, expAhb);
      check(gpioApbSel, 10'(~expAhb & ~AHB_ONLY));
    end
    // each source once in normal mode, then legacy mode with source 1 on a fifth pass
    for (i = 0; i < 5; i++) begin
      div  = 10'(xs());
      pd   = xs() & 32'h0030_0000;
      mask = 16'(xs()) | 16'h0001;
      pw   = xs() & 32'h0000_0331;
      pw[4] = pw[4] | pw[5];
      gate = i[0];
      leg  = (i == 4);
      src  = leg ? 2'h1 : 2'(i);
      apb(1'h1, DSC_OFF_CLKCFG, pd | ((i % 4) << 16) | div);
      apb(1'h0, DSC_OFF_CLKCFG, 32'h0);
      check(rd, pd | ((i % 4) << 16) | div);
      apb(1'h1, DSC_OFF_LEGACY, (((i + 1) % 4) << 16) | div[5:0]);
      apb(1'h1, DSC_OFF_POWER, pw);
      apb(1'h1, DSC_OFF_PERIPH, {16'h0, mask});
      apb(1'h1, DSC_OFF_CTRL, {29'h0, leg, gate, 1'h1});
      waitFor(1'h1, 1'h1);
      check(clkSrcSel, src);
      check(clkDivide, leg ? {4'h0, div[5:0]} : div);
      check(mainOscOn, !pd[21] || src == 2'h0);
      check(precOscOn, !pd[20] || src == 2'h1);
      check(periphClkEn, gate ? mask : 16'hFFFF);
      check({tempLowPower, regulatorSleep, sramPower, flashLowPower},
            {pw[9:8], pw[5:4], pw[0]});
      periphWake <= ~mask;
      repeat (8) @(posedge ref_clk);
      check(deepSleepActive, gate || mask == 16'hFFFF);
      periphWake <= 16'hFFFF;
      waitFor(1'h0, 1'h0);
      check({clkSrcSel, clkDivide, sramPower, flashLowPower}, 32'h0);
      @(posedge ref_clk);
      periphWake <= 16'h0;
    end
    end_of_test();
  end
endmodule
